// *** design/pcr_consts.vh ***
`ifndef PCR_CONSTS_VH
`define PCR_CONSTS_VH

// Register indices (byte address is four times the index)
`define PCR_IDX_LINE_OUT 8'h0F
`define PCR_IDX_SPK_MIX 8'h10
`define PCR_IDX_SPK_OUT 8'h11
`define PCR_IDX_CONV_MIC 8'h12
`define PCR_IDX_MCLK_DIV 8'h14
`define PCR_IDX_CLK_RATE 8'h15
`define PCR_IDX_RATIO_STAT 8'h40

// Field positions
`define PCR_BIT_LEFT 1
`define PCR_BIT_RIGHT 0
`define PCR_BIT_CONV_L 3
`define PCR_BIT_CONV_R 2
`define PCR_BIT_MIC_L 1
`define PCR_BIT_MIC_R 0
`define PCR_BIT_HALVE 0
`define PCR_BIT_SRC 15
`define PCR_RATIO_HI 13
`define PCR_RATIO_LO 10
`define PCR_FAMILY_HI 9
`define PCR_FAMILY_LO 8
`define PCR_RATE_HI 3
`define PCR_RATE_LO 0

// Reset values
`define PCR_RST_PWR 16'h0000
`define PCR_RST_RATIO 4'h3
`define PCR_RST_FAMILY 2'h0
`define PCR_RST_RATE 4'h8

// Clock family codes
`define PCR_FAM_256 2'h0
`define PCR_FAM_272 2'h1
`define PCR_FAM_250 2'h2

`endif

// *** design/pcr_ratio_decode.v ***
`timescale 1ns/1ps
`include "pcr_consts.vh"

module pcr_ratio_decode (
   // Selection
   input wire [1:0] family,
   input wire [3:0] ratio_code,
   // Result
   output reg [10:0] ratio_mult,
   output reg ratio_valid
);

   // ---------------------------------------------------------------
   // Multiplier lookup
   // ---------------------------------------------------------------
   always @* begin
      ratio_mult = 11'h000;
      ratio_valid = 1'b1;
      case (family)
         `PCR_FAM_256: begin
            case (ratio_code)
               4'h0: ratio_mult = 11'd64;
               4'h1: ratio_mult = 11'd128;
               4'h2: ratio_mult = 11'd192;
               4'h3: ratio_mult = 11'd256;
               4'h4: ratio_mult = 11'd384;
               4'h5: ratio_mult = 11'd512;
               4'h6: ratio_mult = 11'd768;
               4'h7: ratio_mult = 11'd1024;
               4'h8: ratio_mult = 11'd1408;
               4'h9: ratio_mult = 11'd1536;
               default: ratio_valid = 1'b0; // RULE_09
            endcase
         end
         `PCR_FAM_272: begin
            case (ratio_code)
               4'h0: ratio_mult = 11'd68;
               4'h1: ratio_mult = 11'd136;
               4'h2: ratio_mult = 11'd204;
               4'h3: ratio_mult = 11'd272;
               4'h4: ratio_mult = 11'd408;
               4'h5: ratio_mult = 11'd544;
               4'h6: ratio_mult = 11'd816;
               4'h7: ratio_mult = 11'd1088;
               4'h8: ratio_mult = 11'd1496;
               4'h9: ratio_mult = 11'd1632;
               default: ratio_valid = 1'b0; // RULE_10
            endcase
         end
         `PCR_FAM_250: begin
            case (ratio_code)
               4'h0: ratio_mult = 11'd125;
               4'h1: ratio_mult = 11'd125;
               4'h2: ratio_mult = 11'd250;
               4'h3: ratio_mult = 11'd250;
               4'h4: ratio_mult = 11'd375;
               4'h5: ratio_mult = 11'd500;
               4'h6: ratio_mult = 11'd750;
               4'h7: ratio_mult = 11'd1000;
               4'h8: ratio_mult = 11'd1000;
               4'h9: ratio_mult = 11'd1500;
               default: ratio_valid = 1'b0;
            endcase
         end
         default: ratio_valid = 1'b0; // RULE_11
      endcase
   end

endmodule

// *** design/pcr_regs.v ***
// Overview of operation
// RULE_01: 0x0F bits 1/0 enable line outputs
// RULE_02: 0x10 bits 1/0 enable speaker mixers
// RULE_03: 0x11 bits 1/0 enable speaker drivers
// RULE_04: 0x12 bits 3/2 enable converters
// RULE_05: 0x12 bits 1/0 enable digital mics
// RULE_06: 0x15 bit 15 selects loop clock source
// RULE_07: 0x14 bit 0 halves master clock
// RULE_08: 0x15 bits 13:10 ratio, reset 0011
// RULE_09: 256 family codes 0-9, rest reserved
// RULE_10: 272 family codes map 68 to 1632
// RULE_11: 0x15 bits 9:8 select family, reset 00
// RULE_12: Enables drive outputs straight from registers
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`include "pcr_consts.vh"

module pcr_regs (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output wire pready,
   output wire pslverr,
   output reg [31:0] prdata,
   // Path enables
   output wire left_line_out_en,
   output wire right_line_out_en,
   output wire left_spk_mixer_en,
   output wire right_spk_mixer_en,
   output wire left_spk_driver_en,
   output wire right_spk_driver_en,
   output wire left_converter_en,
   output wire right_converter_en,
   output wire left_digital_mic_en,
   output wire right_digital_mic_en,
   // Clock configuration
   output wire master_clock_halve,
   output wire sys_clock_source_sel,
   output wire [3:0] sys_clock_ratio,
   output wire [1:0] sys_clock_family,
   output wire [3:0] sample_rate_sel,
   output reg [10:0] ratio_mult,
   output reg ratio_valid
);

   // ---------------------------------------------------------------
   // Register storage
   // ---------------------------------------------------------------
   reg [1:0] line_out_ff;
   reg [1:0] spk_mix_ff;
   reg [1:0] spk_out_ff;
   reg [3:0] conv_mic_ff;
   reg halve_ff;
   reg src_ff;
   reg [3:0] ratio_ff;
   reg [1:0] family_ff;
   reg [3:0] rate_ff;

   wire [9:0] idx;
   wire wr_en;
   wire lo_wr;
   wire hi_wr;
   wire hit;
   wire [10:0] nxt_ratio_mult;
   wire nxt_ratio_valid;
   reg [15:0] rd_word;
   reg rd_hit;

   assign idx = paddr[11:2];
   assign wr_en = psel & penable & pwrite;
   assign lo_wr = wr_en & pstrb[0];
   assign hi_wr = wr_en & pstrb[1];
   assign pready = 1'b1;
   assign hit = rd_hit & (paddr[1:0] == 2'b00);
   assign pslverr = psel & penable & ~hit;

   // ---------------------------------------------------------------
   // Writes
   // ---------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_out_ff <= 2'h0;
         spk_mix_ff <= 2'h0;
         spk_out_ff <= 2'h0;
         conv_mic_ff <= 4'h0;
         halve_ff <= 1'b0;
         src_ff <= 1'b0;
         ratio_ff <= `PCR_RST_RATIO;
         family_ff <= `PCR_RST_FAMILY;
         rate_ff <= `PCR_RST_RATE;
      end else if (paddr[1:0] == 2'b00) begin
         if (lo_wr && idx == {2'b00, `PCR_IDX_LINE_OUT}) begin
            line_out_ff <= pwdata[1:0]; // RULE_01
         end
         if (lo_wr && idx == {2'b00, `PCR_IDX_SPK_MIX}) begin
            spk_mix_ff <= pwdata[1:0]; // RULE_02
         end
         if (lo_wr && idx == {2'b00, `PCR_IDX_SPK_OUT}) begin
            spk_out_ff <= pwdata[1:0]; // RULE_03
         end
         if (lo_wr && idx == {2'b00, `PCR_IDX_CONV_MIC}) begin
            conv_mic_ff <= pwdata[3:0]; // RULE_04 RULE_05
         end
         if (lo_wr && idx == {2'b00, `PCR_IDX_MCLK_DIV}) begin
            halve_ff <= pwdata[`PCR_BIT_HALVE]; // RULE_07
         end
         if (idx == {2'b00, `PCR_IDX_CLK_RATE}) begin
            if (hi_wr) begin
               src_ff <= pwdata[`PCR_BIT_SRC]; // RULE_06
               ratio_ff <= pwdata[`PCR_RATIO_HI:`PCR_RATIO_LO]; // RULE_08
               family_ff <= pwdata[`PCR_FAMILY_HI:`PCR_FAMILY_LO]; // RULE_11
            end
            if (lo_wr) begin
               rate_ff <= pwdata[`PCR_RATE_HI:`PCR_RATE_LO];
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Read mux
   // ---------------------------------------------------------------
   always @* begin
      rd_word = 16'h0000;
      rd_hit = 1'b1;
      case (idx)
         {2'b00, `PCR_IDX_LINE_OUT}: rd_word = {14'h0000, line_out_ff};
         {2'b00, `PCR_IDX_SPK_MIX}: rd_word = {14'h0000, spk_mix_ff};
         {2'b00, `PCR_IDX_SPK_OUT}: rd_word = {14'h0000, spk_out_ff};
         {2'b00, `PCR_IDX_CONV_MIC}: rd_word = {12'h000, conv_mic_ff};
         {2'b00, `PCR_IDX_MCLK_DIV}: rd_word = {15'h0000, halve_ff};
         {2'b00, `PCR_IDX_CLK_RATE}: begin
            rd_word = {src_ff, 1'b0, ratio_ff, family_ff, 4'h0, rate_ff};
         end
         {2'b00, `PCR_IDX_RATIO_STAT}: begin
            rd_word = {4'h0, ratio_valid, ratio_mult};
         end
         default: rd_hit = 1'b0;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= {16'h0000, rd_word};
      end
   end

   // ---------------------------------------------------------------
   // Ratio decode
   // ---------------------------------------------------------------
   pcr_ratio_decode u_decode (
      .family(family_ff),
      .ratio_code(ratio_ff),
      .ratio_mult(nxt_ratio_mult),
      .ratio_valid(nxt_ratio_valid)
   );

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ratio_mult <= 11'd256;
         ratio_valid <= 1'b1;
      end else begin
         ratio_mult <= nxt_ratio_mult; // RULE_09 RULE_10
         ratio_valid <= nxt_ratio_valid;
      end
   end

   // ---------------------------------------------------------------
   // Outputs straight from storage
   // ---------------------------------------------------------------
   assign left_line_out_en = line_out_ff[`PCR_BIT_LEFT]; // RULE_12
   assign right_line_out_en = line_out_ff[`PCR_BIT_RIGHT]; // RULE_12
   assign left_spk_mixer_en = spk_mix_ff[`PCR_BIT_LEFT];
   assign right_spk_mixer_en = spk_mix_ff[`PCR_BIT_RIGHT];
   assign left_spk_driver_en = spk_out_ff[`PCR_BIT_LEFT];
   assign right_spk_driver_en = spk_out_ff[`PCR_BIT_RIGHT];
   assign left_converter_en = conv_mic_ff[`PCR_BIT_CONV_L];
   assign right_converter_en = conv_mic_ff[`PCR_BIT_CONV_R];
   assign left_digital_mic_en = conv_mic_ff[`PCR_BIT_MIC_L];
   assign right_digital_mic_en = conv_mic_ff[`PCR_BIT_MIC_R];
   assign master_clock_halve = halve_ff;
   assign sys_clock_source_sel = src_ff;
   assign sys_clock_ratio = ratio_ff;
   assign sys_clock_family = family_ff;
   assign sample_rate_sel = rate_ff;

endmodule

// *** test/pcr_regs_sva.sv ***
`timescale 1ns/1ps
module pcr_regs_sva (
   // Bus
   input logic pclk, presetn, psel, penable, pwrite,
   input logic [11:0] paddr,
   input logic [31:0] pwdata,
   input logic [3:0] pstrb,
   // Fields
   input logic left_line_out_en, right_line_out_en,
   input logic left_spk_mixer_en, right_spk_mixer_en,
   input logic left_spk_driver_en, right_spk_driver_en,
   input logic left_converter_en, right_converter_en,
   input logic left_digital_mic_en, right_digital_mic_en,
   input logic master_clock_halve, sys_clock_source_sel,
   input logic [3:0] sys_clock_ratio,
   input logic [1:0] sys_clock_family
);
   logic lo;
   logic hi;
   // Completed write per byte lane
   assign lo = psel & penable & pwrite & pstrb[0];
   assign hi = psel & penable & pwrite & pstrb[1];
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_line_wr: assert property (lo && paddr == 12'h03C |=>
      {left_line_out_en, right_line_out_en} == $past(pwdata[1:0]))
      else $error("line out enable");
   a_mix_wr: assert property (lo && paddr == 12'h040 |=>
      {left_spk_mixer_en, right_spk_mixer_en} == $past(pwdata[1:0]))
      else $error("mixer enable");
   a_spk_wr: assert property (lo && paddr == 12'h044 |=>
      {left_spk_driver_en, right_spk_driver_en} == $past(pwdata[1:0]))
      else $error("driver enable");
   a_conv_wr: assert property (lo && paddr == 12'h048 |=>
      {left_converter_en, right_converter_en} == $past(pwdata[3:2]))
      else $error("converter enable");
   a_mic_wr: assert property (lo && paddr == 12'h048 |=>
      {left_digital_mic_en, right_digital_mic_en} == $past(pwdata[1:0]))
      else $error("mic enable");
   a_halve_wr: assert property (lo && paddr == 12'h050 |=>
      master_clock_halve == $past(pwdata[0])) else $error("halve");
   a_src_wr: assert property (hi && paddr == 12'h054 |=>
      sys_clock_source_sel == $past(pwdata[15])) else $error("source");
   a_ratio_wr: assert property (hi && paddr == 12'h054 |=>
      sys_clock_ratio == $past(pwdata[13:10])) else $error("ratio");
   a_family_wr: assert property (hi && paddr == 12'h054 |=>
      sys_clock_family == $past(pwdata[9:8])) else $error("family");
   a_line_hold: assert property (!(lo && paddr == 12'h03C) |=>
      $stable({left_line_out_en, right_line_out_en}))
      else $error("line out changed");
   a_reset_val: assert property ($rose(presetn) |->
      sys_clock_ratio == 4'h3 && sys_clock_family == 2'h0)
      else $error("reset values");
endmodule
bind pcr_regs pcr_regs_sva SVA (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pstrb, .left_line_out_en, .right_line_out_en,
   .left_spk_mixer_en, .right_spk_mixer_en, .left_spk_driver_en,
   .right_spk_driver_en, .left_converter_en, .right_converter_en,
   .left_digital_mic_en, .right_digital_mic_en, .master_clock_halve,
   .sys_clock_source_sel, .sys_clock_ratio, .sys_clock_family);

// *** test/power_and_clock_rate_regs_tb.sv ***
`timescale 1ns/1ps
module power_and_clock_rate_regs_tb;
   logic pclk = 0;
   logic presetn = 0;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0;
   logic [3:0] pstrb = 4'hF;
   logic [31:0] prdata, rd;
   logic pready, pslverr, se, halve, src, rv;
   logic [9:0] en;
   logic [3:0] ratio, rate;
   logic [1:0] fam;
   logic [10:0] mult;
   integer err_total = 0;
   integer total_checks = 0;
   integer m256 [0:9] = '{64, 128, 192, 256, 384, 512, 768, 1024, 1408, 1536};
   integer m272 [0:9] = '{68, 136, 204, 272, 408, 544, 816, 1088, 1496,
      1632};
   integer m250 [0:9] = '{125, 125, 250, 250, 375, 500, 750, 1000, 1000,
      1500};
   always #25 pclk = ~pclk;
   pcr_regs DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb, .pready, .pslverr, .prdata,
      .left_line_out_en(en[9]), .right_line_out_en(en[8]),
      .left_spk_mixer_en(en[7]), .right_spk_mixer_en(en[6]),
      .left_spk_driver_en(en[5]), .right_spk_driver_en(en[4]),
      .left_converter_en(en[3]), .right_converter_en(en[2]),
      .left_digital_mic_en(en[1]), .right_digital_mic_en(en[0]),
      .master_clock_halve(halve), .sys_clock_source_sel(src),
      .sys_clock_ratio(ratio), .sys_clock_family(fam),
      .sample_rate_sel(rate), .ratio_mult(mult), .ratio_valid(rv));
   // ----
   // Helpers
   // ----
   task complete_run;
      begin
         $display("checks %0d mismatches %0d", total_checks, err_total);
         if (err_total == 0 && total_checks > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      integer n;
      begin
         @(posedge pclk);
         psel <= 1'h1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'h1;
         n = 0;
         do begin
            @(posedge pclk);
            n = n + 1;
         end while (pready !== 1'h1 && n < 16);
         if (pready !== 1'h1) begin
            err_total = err_total + 1;
            complete_run;
         end else begin
            rd = prdata;
            se = pslverr;
            psel <= 1'h0;
            penable <= 1'h0;
         end
      end
   endtask
   task cfg(input logic [1:0] f, input integer c);
      begin
         apb(1'h1, 12'h054, {c[3:0], f, 8'h08});
         @(posedge pclk);
         @(negedge pclk);
      end
   endtask
   // ----
   // Scenarios
   // ----
   task t_reset;
      begin
         presetn <= 1'h0;
         repeat (12) @(posedge pclk);
         presetn <= 1'h1;
         @(negedge pclk);
         chk({en, halve, src, fam}, 0);
         chk({ratio, rate}, 8'h38);
         chk({rv, mult}, {1'h1, 11'd256});
         apb(1'h0, 12'h054, 0);
         chk(rd, 32'h0000_0C08);
      end
   endtask
   task t_power(input logic [9:0] e, input logic [31:0] pad);
      begin
         apb(1'h1, 12'h03C, pad | e[9:8]);
         apb(1'h1, 12'h040, pad | e[7:6]);
         apb(1'h1, 12'h044, pad | e[5:4]);
         apb(1'h1, 12'h048, pad | e[3:0]);
         @(negedge pclk);
         chk(en, e);
         apb(1'h0, 12'h048, 0);
         chk(rd, e[3:0]);
      end
   endtask
   task t_bad;
      begin
         apb(1'h1, 12'h03D, 32'h3);
         chk(se, 1'h1);
         apb(1'h0, 12'h00C, 0);
         @(negedge pclk);
         chk(en[9:8], 2'h1);
         chk(se, 1'h1);
         chk(rd, 0);
      end
   endtask
   task t_clock;
      begin
         apb(1'h1, 12'h050, 32'h1);
         apb(1'h1, 12'h054, 32'hA503);
         @(negedge pclk);
         chk({halve, src}, 2'h3);
         chk({ratio, fam, rate}, 10'h253);
         apb(1'h0, 12'h054, 0);
         chk(rd, 32'h0000_A503);
         chk(se, 1'h0);
         apb(1'h0, 12'h100, 0);
         chk(rd, 32'h0000_0E60);
         @(posedge pclk);
         pstrb <= 4'h1;
         apb(1'h1, 12'h054, 32'h0000_0005);
         pstrb <= 4'hF;
         @(negedge pclk);
         chk({halve, src, ratio, fam, rate}, 12'hE55);
      end
   endtask
   task t_ratio;
      integer c;
      begin
         for (c = 0; c < 11; c = c + 1) begin
            cfg(2'h0, c);
            chk({rv, mult}, c < 10 ? {1'h1, m256[c][10:0]} : 0);
         end
         for (c = 0; c < 11; c = c + 1) begin
            cfg(2'h1, c);
            chk({rv, mult}, c < 10 ? {1'h1, m272[c][10:0]} : 0);
         end
         for (c = 0; c < 11; c = c + 1) begin
            cfg(2'h2, c);
            chk({rv, mult}, c < 10 ? {1'h1, m250[c][10:0]} : 0);
         end
         cfg(2'h3, 3);
         chk({rv, mult, src}, 0);
      end
   endtask
   initial begin
      t_reset;
      t_power(10'h26A, 32'h0);
      t_power(10'h195, 32'hFFFF_0000);
      t_bad;
      t_clock;
      t_ratio;
      @(posedge pclk);
      t_reset;
      complete_run;
   end
endmodule
